// >>> ucf_uart.sv
// serial transceiver with fifos, flow control, dma requests and interrupts
// Functional notes
// - on disable, the character in the shifter finishes before stopping
// - disable discards everything still waiting in the transmit queue
// - global enable starts transmit, receive and turns on both fifos
// - infrared select writes ignored while enabled; taken only when disabled
// - infrared plus low-power option selects the low-power pulse mode
// - receive and transmit dma request enables, set or cleared separately
// - stop-on-error clears receive dma enable on any receive error
// - fifos disabled makes both paths run without their fifos
// - tx and rx interrupt thresholds at 1,2,4,6,7 eighths, set separately
// - with transmit handshake, a character starts only while cts asserted
// - with receive handshake, rts asserted only while rx fifo has room
// - both handshake modes independent, may be off, and read back
// - writing a clear mask deasserts exactly those interrupt sources
// - per-source mask; only unmasked reach the line; raw and masked readable
// - sources: address, overrun, break, parity, framing, timeout, tx, rx, modem
// - five to eight data bits, one or two stops, five parity modes
`include "ucf_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ucf_uart #(
  parameter int DEPTH = 16,
  parameter int AW = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output logic irq_o,
  input wire logic rxd_i,
  output logic txd_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic dcd_n_i,
  input wire logic ri_n_i,
  output logic rts_n_o,
  output logic ir_lowpower_o,
  output logic dma_rx_req_o,
  output logic dma_tx_req_o
);
  // control registers
  logic en_q, fifo_q, ir_q, irlp_q;
  logic [2:0] dma_q;
  logic [1:0] flow_q;
  logic [2:0] txlvl_q, rxlvl_q;
  ucf_pkg::ucf_frame_type frame_q;
  logic [15:0] baud_q;
  logic [`UCF_NINT-1:0] ris_q, mask_q;
  logic [31:0] rdata_q;
  // pin synchronisers, first stage read only by second
  logic [4:0] sy1_q, sy2_q;
  logic [3:0] modem_q;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sy1_q <= 5'h1F;
      sy2_q <= 5'h1F;
      modem_q <= 4'hF;
    end else begin
      sy1_q <= {rxd_i, cts_n_i, dsr_n_i, dcd_n_i, ri_n_i};
      sy2_q <= sy1_q;
      modem_q <= sy2_q[3:0];
    end
  end
  wire rxd_s = sy2_q[4];
  wire cts_ok = !sy2_q[3];
  wire [3:0] modem_chg = sy2_q[3:0] ^ modem_q;
  // bus decode
  wire wr_ctrl = wr_i && addr_i == `UCF_ADDR_CTRL;
  wire wr_data = wr_i && addr_i == `UCF_ADDR_DATA;
  wire rd_data = rd_i && addr_i == `UCF_ADDR_DATA;
  wire rd_ris = rd_i && addr_i == `UCF_ADDR_RIS;
  wire wr_clr = wr_i && addr_i == `UCF_ADDR_CLEAR;
  function automatic logic [AW:0] thresh(input logic [2:0] lv);
    logic [AW+3:0] t;
    t = '0;
    unique case (lv)
      3'h0: t = (AW+4)'(DEPTH);
      3'h1: t = (AW+4)'(DEPTH * 2);
      3'h2: t = (AW+4)'(DEPTH * 4);
      3'h3: t = (AW+4)'(DEPTH * 6);
      default: t = (AW+4)'(DEPTH * 7);
    endcase
    return t[AW+3:3];
  endfunction
  // fifos; depth one when fifos are off
  wire [AW:0] cap = fifo_q ? (AW+1)'(DEPTH) : (AW+1)'(1);
  logic [7:0] txm [DEPTH];
  logic [7:0] rxm [DEPTH];
  logic [AW-1:0] txw_q, txr_q, rxw_q, rxr_q;
  logic [AW:0] txc_q, rxc_q;
  wire tx_full = txc_q >= cap;
  wire rx_full = rxc_q >= cap;
  // transmit shifter
  logic [10:0] tsh_q;
  logic [3:0] tbits_q;
  logic [15:0] tdiv_q;
  wire tx_busy = tbits_q != 4'h0;
  wire [3:0] nbits = 4'(frame_q.data_bits_less5) + 4'h5;
  wire tx_pop = en_q && !tx_busy && txc_q != '0 &&
    (!flow_q[`UCF_FLOW_TX] || cts_ok);
  wire tx_push = wr_data && !tx_full;
  logic [7:0] tbyte;
  logic tpar;
  logic [10:0] tframe;
  logic [3:0] tlen;
  always_comb begin
    tbyte = txm[txr_q] & (8'hFF >> (4'h8 - nbits));
    tpar = ^tbyte;
    unique case (frame_q.parity)
      ucf_pkg::UCF_PAR_EVEN: tpar = ^tbyte;
      ucf_pkg::UCF_PAR_ODD: tpar = ~^tbyte;
      ucf_pkg::UCF_PAR_ONE: tpar = 1'b1;
      ucf_pkg::UCF_PAR_ZERO: tpar = 1'b0;
      default: tpar = 1'b0;
    endcase
    tframe = 11'h7FF;
    tframe[7:0] = tbyte;
    if (frame_q.parity != ucf_pkg::UCF_PAR_NONE) tframe[nbits] = tpar;
    tlen = nbits + 4'h2 + 4'(frame_q.two_stop) +
      4'(frame_q.parity != ucf_pkg::UCF_PAR_NONE);
  end
  // shifter keeps running after disable until the character ends
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      tsh_q <= 11'h7FF;
      tbits_q <= 4'h0;
      tdiv_q <= 16'h0000;
    end else if (tx_pop) begin
      tsh_q <= {tframe[9:0], 1'b0};
      tbits_q <= tlen;
      tdiv_q <= baud_q;
    end else if (tx_busy) begin
      tdiv_q <= tdiv_q == 16'h0000 ? baud_q : tdiv_q - 16'h0001;
      if (tdiv_q == 16'h0000) begin
        tsh_q <= {1'b1, tsh_q[10:1]};
        tbits_q <= tbits_q - 4'h1;
      end
    end
  end
  // ir pulse: low-power mode narrows the pulse to one clock
  wire bit_start = tdiv_q == baud_q;
  wire ir_pulse = !tsh_q[0] && (irlp_q ? bit_start : tdiv_q > baud_q / 2);
  assign txd_o = ir_q ? !ir_pulse : (tx_busy ? tsh_q[0] : 1'b1);
  assign ir_lowpower_o = ir_q && irlp_q;
  // transmit queue, flushed while disabled
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      txw_q <= '0;
      txr_q <= '0;
      txc_q <= '0;
    end else if (!en_q) begin
      txw_q <= '0;
      txr_q <= '0;
      txc_q <= '0;
    end else begin
      if (tx_push) txm[txw_q] <= wdata_i[7:0];
      if (tx_push) txw_q <= fifo_q ? txw_q + 1'b1 : '0;
      if (tx_pop) txr_q <= fifo_q ? txr_q + 1'b1 : '0;
      txc_q <= txc_q + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
    end
  end
  // receiver: samples mid-bit
  logic [3:0] rbits_q;
  logic [15:0] rdiv_q;
  logic [10:0] rsh_q;
  logic [7:0] idle_q;
  // free baud tick; the tx divider only runs while a character is sent
  logic [15:0] bdiv_q;
  wire rx_busy = rbits_q != 4'h0;
  wire rx_start = en_q && !rx_busy && !rxd_s;
  wire rsample = rx_busy && rdiv_q == 16'h0000;
  wire rx_done = rsample && rbits_q == 4'h1;
  wire [10:0] rfr = {rxd_s, rsh_q[10:1]} >> (4'hB - tlen);
  wire [7:0] rbyte = rfr[8:1] & (8'hFF >> (4'h8 - nbits));
  wire has_par = frame_q.parity != ucf_pkg::UCF_PAR_NONE;
  logic rpar_exp;
  always_comb begin
    unique case (frame_q.parity)
      ucf_pkg::UCF_PAR_ODD: rpar_exp = ~^rbyte;
      ucf_pkg::UCF_PAR_ONE: rpar_exp = 1'b1;
      ucf_pkg::UCF_PAR_ZERO: rpar_exp = 1'b0;
      default: rpar_exp = ^rbyte;
    endcase
  end
  wire par_err = rx_done && has_par && rfr[nbits+1] != rpar_exp;
  wire frm_err = rx_done && !rxd_s;
  wire brk_err = frm_err && rfr == 11'h000;
  wire ovr_err = rx_done && rx_full;
  wire addr_ev = rx_done && has_par && rfr[nbits+1];
  wire rx_push = rx_done && !rx_full;
  wire rx_pop = rd_data && rxc_q != '0;
  wire rx_err = par_err || frm_err || brk_err || ovr_err;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rbits_q <= 4'h0;
      rdiv_q <= 16'h0000;
      rsh_q <= 11'h000;
    end else if (rx_start) begin
      rbits_q <= tlen;
      rdiv_q <= baud_q >> 1;
    end else if (rx_busy) begin
      rdiv_q <= rsample ? baud_q : rdiv_q - 16'h0001;
      if (rsample) begin
        rsh_q <= {rxd_s, rsh_q[10:1]};
        rbits_q <= rbits_q - 4'h1;
      end
    end
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rxw_q <= '0;
      rxr_q <= '0;
      rxc_q <= '0;
      idle_q <= 8'h00;
      bdiv_q <= 16'h0000;
    end else begin
      bdiv_q <= bdiv_q == 16'h0000 ? baud_q : bdiv_q - 16'h0001;
      if (rx_push) rxm[rxw_q] <= rbyte;
      if (rx_push) rxw_q <= fifo_q ? rxw_q + 1'b1 : '0;
      if (rx_pop) rxr_q <= fifo_q ? rxr_q + 1'b1 : '0;
      rxc_q <= rxc_q + (AW+1)'(rx_push) - (AW+1)'(rx_pop);
      idle_q <= (rx_busy || rx_pop || rxc_q == '0) ? 8'h00 :
        (bdiv_q == 16'h0000 && idle_q != 8'hFF ? idle_q + 8'h01 : idle_q);
    end
  end
  wire rto_ev = idle_q == 8'(`UCF_RTO_CHARS);
  // handshake output follows rx fifo room only in receive handshake mode, else held asserted (low)
  assign rts_n_o = flow_q[`UCF_FLOW_RX] ? rx_full : 1'b0;
  // thresholds; without fifos they reduce to full/empty
  wire tx_lvl = fifo_q ? (txc_q <= thresh(txlvl_q)) : !tx_full;
  wire rx_lvl = fifo_q ? (rxc_q >= thresh(rxlvl_q) && rxc_q != '0) : rx_full;
  logic tx_lvl_q, rx_lvl_q;
  // interrupt sources
  wire [`UCF_NINT-1:0] ev = {modem_chg[0], modem_chg[3], modem_chg[1],
    modem_chg[2], rx_lvl && !rx_lvl_q, tx_lvl && !tx_lvl_q, rto_ev,
    frm_err, par_err, brk_err, ovr_err, addr_ev};
  wire [`UCF_NINT-1:0] mis = ris_q & mask_q;
  assign irq_o = |mis;
  assign dma_rx_req_o = dma_q[`UCF_DMA_RX] && rxc_q != '0;
  assign dma_tx_req_o = dma_q[`UCF_DMA_TX] && !tx_full;
  wire [`UCF_NINT-1:0] clr = wr_clr ? wdata_i[`UCF_NINT-1:0] : '0;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      en_q <= 1'b0;
      fifo_q <= 1'b0;
      ir_q <= 1'b0;
      irlp_q <= 1'b0;
      dma_q <= 3'h0;
      flow_q <= 2'h0;
      txlvl_q <= 3'h2;
      rxlvl_q <= 3'h2;
      frame_q <= '0;
      baud_q <= `UCF_BAUD_RESET;
      mask_q <= '0;
      ris_q <= '0;
      tx_lvl_q <= 1'b0;
      rx_lvl_q <= 1'b0;
    end else begin
      tx_lvl_q <= tx_lvl;
      rx_lvl_q <= rx_lvl;
      if (wr_ctrl) begin
        en_q <= wdata_i[`UCF_CTRL_EN];
        // enabling forces the fifos on; later writes may turn them off
        fifo_q <= wdata_i[`UCF_CTRL_FIFO] |
          (wdata_i[`UCF_CTRL_EN] & !en_q);
        if (!en_q) begin
          ir_q <= wdata_i[`UCF_CTRL_IR];
          irlp_q <= wdata_i[`UCF_CTRL_IRLP];
        end
      end
      if (wr_i && addr_i == `UCF_ADDR_FRAME) frame_q <= wdata_i[5:0];
      if (wr_i && addr_i == `UCF_ADDR_LEVEL) begin
        txlvl_q <= wdata_i[2:0];
        rxlvl_q <= wdata_i[5:3];
      end
      if (wr_i && addr_i == `UCF_ADDR_DMA) dma_q <= wdata_i[2:0];
      else if (dma_q[`UCF_DMA_STOP] && rx_err)
        dma_q[`UCF_DMA_RX] <= 1'b0;
      if (wr_i && addr_i == `UCF_ADDR_FLOW) flow_q <= wdata_i[1:0];
      if (wr_i && addr_i == `UCF_ADDR_BAUD) baud_q <= wdata_i[15:0];
      if (wr_i && addr_i == `UCF_ADDR_MASK) mask_q <= wdata_i[11:0];
      // new events win over a clear or read-clear in the same cycle
      ris_q <= ((rd_ris ? '0 : ris_q) & ~clr) | ev;
    end
  end
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    unique case (addr_i)
      `UCF_ADDR_CTRL: rd_mux = {28'h0, irlp_q, ir_q, fifo_q, en_q};
      `UCF_ADDR_FRAME: rd_mux = {26'h0, frame_q};
      `UCF_ADDR_LEVEL: rd_mux = {26'h0, rxlvl_q, txlvl_q};
      `UCF_ADDR_DMA: rd_mux = {29'h0, dma_q};
      `UCF_ADDR_FLOW: rd_mux = {30'h0, flow_q};
      `UCF_ADDR_RIS: rd_mux = {20'h0, ris_q};
      `UCF_ADDR_MASK: rd_mux = {20'h0, mask_q};
      `UCF_ADDR_MIS: rd_mux = {20'h0, mis};
      `UCF_ADDR_DATA: rd_mux = {24'h0, rxm[rxr_q]};
      `UCF_ADDR_STAT: rd_mux = {26'h0, tx_busy, rx_busy, tx_full,
        txc_q == '0, rx_full, rxc_q == '0};
      `UCF_ADDR_BAUD: rd_mux = {16'h0, baud_q};
      default: rd_mux = 32'h00000000;
    endcase
  end
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) rdata_q <= 32'h00000000;
    else rdata_q <= rd_i ? rd_mux : 32'h00000000;
  end
  assign rdata_o = rdata_q;
  a_flush_queue: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !en_q |=> txc_q == '0) else $error("queue not flushed");
  a_cts_gate: assert property (@(posedge clk_i) disable iff (!rstn_i)
    tx_pop && flow_q[0] |-> cts_ok) else $error("sent without cts");
  a_rts_room: assert property (@(posedge clk_i) disable iff (!rstn_i)
    flow_q[1] && !rts_n_o |-> rxc_q < cap) else $error("rts no room");
  a_ir_locked: assert property (@(posedge clk_i) disable iff (!rstn_i)
    en_q && $past(en_q) |-> $stable(ir_q)) else $error("ir changed");
  a_dma_stop: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dma_q[2] && rx_err && !wr_i |=> !dma_q[0]) else $error("dma on");
  a_clear_src: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_clr && !ev[0] && wdata_i[0] |=> !ris_q[0])
    else $error("clear failed");
  a_irq_mask: assert property (@(posedge clk_i) disable iff (!rstn_i)
    irq_o |-> |(ris_q & mask_q)) else $error("masked irq");
  sequence s_tx_end;
    tx_busy ##1 !tx_busy;
  endsequence
  a_char_finish: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !en_q && tx_busy && (tbits_q != 4'h1 || tdiv_q != 16'h0000) |=> tx_busy)
    else $error("char cut");
  a_char_end: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !en_q && tbits_q == 4'h1 && tdiv_q == 16'h0000 |-> s_tx_end)
    else $error("char overrun");
  a_en_fifo: assert property (@(posedge clk_i) disable iff (!rstn_i)
    wr_ctrl && wdata_i[0] && !en_q |=> en_q && fifo_q)
    else $error("no fifo");
  a_fifo_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
    !fifo_q && rx_push |=> rx_full)
    else $error("holding register not full");
  a_dma_tx: assert property (@(posedge clk_i) disable iff (!rstn_i)
    dma_tx_req_o |-> dma_q[`UCF_DMA_TX] && !tx_full)
    else $error("tx dma request while off");
endmodule // ucf_uart
`default_nettype wire

// >>> ucf_consts.svh
// register offsets, field positions, reset values and timing counts
`ifndef UCF_CONSTS_SVH
`define UCF_CONSTS_SVH
`define UCF_ADDR_CTRL 8'h00
`define UCF_ADDR_FRAME 8'h04
`define UCF_ADDR_LEVEL 8'h08
`define UCF_ADDR_DMA 8'h0C
`define UCF_ADDR_FLOW 8'h10
`define UCF_ADDR_RIS 8'h14
`define UCF_ADDR_MASK 8'h18
`define UCF_ADDR_MIS 8'h1C
`define UCF_ADDR_CLEAR 8'h20
`define UCF_ADDR_DATA 8'h24
`define UCF_ADDR_STAT 8'h28
`define UCF_ADDR_BAUD 8'h2C
`define UCF_CTRL_EN 0
`define UCF_CTRL_FIFO 1
`define UCF_CTRL_IR 2
`define UCF_CTRL_IRLP 3
`define UCF_DMA_RX 0
`define UCF_DMA_TX 1
`define UCF_DMA_STOP 2
`define UCF_FLOW_TX 0
`define UCF_FLOW_RX 1
`define UCF_INT_ADDR 0
`define UCF_INT_OVR 1
`define UCF_INT_BRK 2
`define UCF_INT_PAR 3
`define UCF_INT_FRM 4
`define UCF_INT_RTO 5
`define UCF_INT_TX 6
`define UCF_INT_RX 7
`define UCF_INT_DSR 8
`define UCF_INT_DCD 9
`define UCF_INT_CTS 10
`define UCF_INT_RI 11
`define UCF_NINT 12
`define UCF_BAUD_RESET 16'h0010
`define UCF_RTO_CHARS 32'h00000020
`endif

// >>> ucf_pkg.sv
// types shared by the serial transceiver control block
package ucf_pkg;
  typedef enum logic [2:0] {
    UCF_LVL_1_8 = 3'h0,
    UCF_LVL_2_8 = 3'h1,
    UCF_LVL_4_8 = 3'h2,
    UCF_LVL_6_8 = 3'h3,
    UCF_LVL_7_8 = 3'h4
  } ucf_level_type;
  typedef enum logic [2:0] {
    UCF_PAR_NONE = 3'h0,
    UCF_PAR_EVEN = 3'h1,
    UCF_PAR_ODD = 3'h2,
    UCF_PAR_ONE = 3'h3,
    UCF_PAR_ZERO = 3'h4
  } ucf_parity_type;
  typedef struct packed {
    logic [1:0] data_bits_less5;
    logic two_stop;
    ucf_parity_type parity;
  } ucf_frame_type;
  typedef struct packed {
    logic dsr;
    logic dcd;
    logic cts;
    logic ri;
  } ucf_modem_type;
endpackage

// >>> ucf_remote.sv
// remote serial party model: 8n1 sender, receiver and cts control
`timescale 1ns/100ps
`default_nettype none
module ucf_remote #(
  parameter int PER = 4
) (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic rts_n_i,
  output logic rxd_o,
  output logic cts_n_o
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial begin
    rxd_o = 1'b1;
    cts_n_o = 1'b0;
  end
  // a frame starts once the device shows room, or after 4000 cycles of waiting
  task automatic send(input logic [7:0] b, input logic bad);
    int n;
    n = 0;
    while (rts_n_i !== 1'b0 && n < 4000) begin
      @(posedge clk_i);
      n++;
    end
    rxd_o <= 1'b0;
    repeat (PER) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rxd_o <= b[i];
      repeat (PER) @(posedge clk_i);
    end
    // a low stop bit gives the device a framing error
    rxd_o <= ~bad;
    repeat (PER) @(posedge clk_i);
    rxd_o <= 1'b1;
    repeat (PER) @(posedge clk_i);
  endtask
  // lsb first, sampled mid-bit
  always begin
    @(negedge txd_i);
    repeat (PER / 2) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (PER) @(posedge clk_i);
      sh[i] = txd_i;
    end
    repeat (PER) @(posedge clk_i);
    got.push_back(sh);
  end
endmodule // ucf_remote
`default_nettype wire

// >>> ucf_uart_bench.sv
// self-checking bench of the serial transceiver control block
`include "ucf_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module ucf_uart_bench;
  localparam int PER = 4;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [31:0] rdata_o;
  logic irq_o, txd_o, rxd_i, cts_n_i, rts_n_o, ir_lowpower_o;
  logic dma_rx_req_o, dma_tx_req_o;
  logic [3:0] mdm_n = 4'hF;
  logic [31:0] seed = 32'h2F55;
  logic [31:0] v;
  logic [7:0] b;
  logic [7:0] q[$];
  int error_cnt = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  always #2 clk_i = ~clk_i;
  ucf_uart i_ucf_uart (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .irq_o(irq_o), .rxd_i(rxd_i), .txd_o(txd_o), .cts_n_i(cts_n_i),
    .dsr_n_i(mdm_n[0]), .dcd_n_i(mdm_n[1]), .ri_n_i(mdm_n[2]),
    .rts_n_o(rts_n_o), .ir_lowpower_o(ir_lowpower_o),
    .dma_rx_req_o(dma_rx_req_o), .dma_tx_req_o(dma_tx_req_o));
  ucf_remote #(.PER(PER)) i_ucf_remote (.clk_i(clk_i), .txd_i(txd_o),
    .rts_n_i(rts_n_o), .rxd_o(rxd_i), .cts_n_o(cts_n_i));
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // bounded wait for the remote to collect k characters
  task automatic wait_got(input int k);
    n = 0;
    while (i_ucf_remote.got.size() < k && n < 200 * PER) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // every modem line changes twice; both edges are events
  task automatic toggle();
    mdm_n <= 4'h0;
    i_ucf_remote.cts_n_o <= 1'b1;
    repeat (8) @(posedge clk_i);
    mdm_n <= 4'hF;
    i_ucf_remote.cts_n_o <= 1'b0;
    repeat (8) @(posedge clk_i);
  endtask
  // generous ceiling: the whole sequence needs well under 10000 cycles
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rstn_i <= 1'b1;
    #1 chk({27'h0, txd_o, irq_o, rts_n_o, dma_rx_req_o, dma_tx_req_o}, 32'h10);
    rd(8'h30, v);
    chk(v, 32'h0); // unmapped address reads zero
    wr(`UCF_ADDR_BAUD, 32'h3);
    wr(`UCF_ADDR_FRAME, 32'h30);
    wr(`UCF_ADDR_CTRL, 32'h1);
    wr(`UCF_ADDR_CTRL, 32'h7);
    rd(`UCF_ADDR_CTRL, v);
    chk(v, 32'h3);
    wr(`UCF_ADDR_CTRL, 32'h0);
    wr(`UCF_ADDR_CTRL, 32'hC);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, ir_lowpower_o}, 32'h1);
    rd(`UCF_ADDR_CTRL, v);
    chk(v, 32'hC);
    wr(`UCF_ADDR_CTRL, 32'h0);
    wr(`UCF_ADDR_CTRL, 32'h1);
    for (int i = 0; i < 5; i++) begin
      wr(`UCF_ADDR_LEVEL, {26'h0, 3'(4 - i), 3'(i)});
      rd(`UCF_ADDR_LEVEL, v);
      chk(v, {26'h0, 3'(4 - i), 3'(i)});
      wr(`UCF_ADDR_FLOW, 32'(i % 4));
      rd(`UCF_ADDR_FLOW, v);
      chk(v, 32'(i % 4));
    end
    wr(`UCF_ADDR_DMA, 32'h2);
    repeat (2) @(posedge clk_i);
    #1 chk({30'h0, dma_rx_req_o, dma_tx_req_o}, 32'h1);
    wr(`UCF_ADDR_DMA, 32'h1);
    repeat (2) @(posedge clk_i);
    #1 chk({30'h0, dma_rx_req_o, dma_tx_req_o}, 32'h0);
    toggle();
    rd(`UCF_ADDR_MIS, v);
    chk({v[11:8], 3'h0, irq_o}, 8'h0);
    wr(`UCF_ADDR_MASK, 32'hF00);
    #1 chk({31'h0, irq_o}, 32'h1);
    rd(`UCF_ADDR_MIS, v);
    chk(v & 32'hF00, 32'hF00);
    wr(`UCF_ADDR_CLEAR, 32'h300);
    rd(`UCF_ADDR_MIS, v);
    chk({v[11:8], 3'h0, irq_o}, 8'hC1);
    wr(`UCF_ADDR_CLEAR, 32'hC00);
    #1 chk({31'h0, irq_o}, 32'h0);
    toggle();
    rd(`UCF_ADDR_RIS, v);
    chk(v & 32'hF00, 32'hF00);
    #1 chk({31'h0, irq_o}, 32'h0);
    wr(`UCF_ADDR_MASK, 32'h0);
    wr(`UCF_ADDR_DMA, 32'h5);
    b = rnd();
    i_ucf_remote.send(b, 1'b0);
    #1 chk({31'h0, dma_rx_req_o}, 32'h1);
    rd(`UCF_ADDR_DATA, v);
    chk(v & 32'hFF, {24'h0, b}); // received byte
    i_ucf_remote.send(rnd(), 1'b1);
    rd(`UCF_ADDR_DMA, v);
    chk(v, 32'h4);
    wr(`UCF_ADDR_DMA, 32'h1);
    i_ucf_remote.send(rnd(), 1'b1);
    rd(`UCF_ADDR_DMA, v);
    chk(v, 32'h1);
    // a low stop bit restarts the receiver; let it settle, then drain
    repeat (12 * PER) @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      rd(`UCF_ADDR_STAT, v);
      if (!v[0]) rd(`UCF_ADDR_DATA, v);
    end
    wr(`UCF_ADDR_DMA, 32'h0);
    wr(`UCF_ADDR_FLOW, 32'h2);
    for (int i = 0; i < 16; i++) begin
      q.push_back(8'(rnd()));
      i_ucf_remote.send(q[i], 1'b0);
    end
    #1 chk({31'h0, rts_n_o}, 32'h1);
    for (int i = 0; i < 16; i++) begin
      rd(`UCF_ADDR_DATA, v);
      chk(v & 32'hFF, {24'h0, q[i]}); // fifo order
      repeat (3) @(posedge clk_i);
      #1 chk({31'h0, rts_n_o}, 32'h0);
    end
    wr(`UCF_ADDR_FLOW, 32'h1);
    i_ucf_remote.cts_n_o <= 1'b1; // remote holds off the sender
    b = rnd();
    wr(`UCF_ADDR_DATA, {24'h0, b});
    repeat (12 * PER) @(posedge clk_i);
    chk(i_ucf_remote.got.size(), 32'h0);
    chk({31'h0, txd_o}, 32'h1);
    i_ucf_remote.cts_n_o <= 1'b0;
    wait_got(1);
    chk(i_ucf_remote.got[0], b);
    b = rnd();
    wr(`UCF_ADDR_DATA, {24'h0, b});
    wr(`UCF_ADDR_DATA, rnd() & 32'hFF);
    repeat (3 * PER) @(posedge clk_i);
    wr(`UCF_ADDR_CTRL, 32'h0);
    wait_got(2);
    chk(i_ucf_remote.got[1], b);
    repeat (20 * PER) @(posedge clk_i);
    chk(i_ucf_remote.got.size(), 2);
    wr(`UCF_ADDR_CTRL, 32'h1);
    repeat (20 * PER) @(posedge clk_i);
    chk(i_ucf_remote.got.size(), 32'h2);
    chk({31'h0, txd_o}, 32'h1);
    wr(`UCF_ADDR_CTRL, 32'h1);
    rd(`UCF_ADDR_CTRL, v);
    chk(v, 32'h1);
    wr(`UCF_ADDR_FLOW, 32'h2);
    b = rnd();
    i_ucf_remote.send(b, 1'b0);
    #1 chk({31'h0, rts_n_o}, 32'h1);
    rd(`UCF_ADDR_DATA, v);
    chk(v & 32'hFF, {24'h0, b});
    stop_test();
  end
endmodule // ucf_uart_bench
`default_nettype wire
